// >>> printer_parallel_port_regs.sv
`timescale 1ns/1ns
module printer_parallel_port_regs
  import pport_pkg::*;
  (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Host register port
    input wire logic [1:0] host_addr,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    // Port configuration
    input wire port_config_t port_config_reg,
    input wire logic epp_cycle_busy,
    output logic epp_regs_present,
    output logic epp_rev19_active,
    // Port data pins
    input wire logic [7:0] port_data_pins_in,
    output logic [7:0] port_data_pins_out,
    output logic port_data_pins_oe,
    // Printer control pins, active low on the cable
    input wire logic [3:0] ctrl_pins_in,
    output logic printer_strobe_n,
    output logic auto_feed_n,
    output logic init_n,
    output logic select_in_n,
    output logic [3:0] ctrl_pins_oe,
    // Printer status pins
    input wire status_pins_t status_pins,
    // Interrupt lines
    output logic irq5,
    output logic irq5_oe,
    output logic irq7,
    output logic irq7_oe
  );

  // Synchronised copies of pins
  logic [1:0] addr_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [7:0] hdata_s;
  logic [7:0] pdata_s;
  logic [3:0] cpin_s;
  status_pins_t st_s;

  pin_sync #(.W(2), .RESET_VAL(2'h0)) u_sync_addr
  (
    .clock(clock),
    .rstn(rstn),
    .async_in(host_addr),
    .sync_out(addr_s)
  );

  pin_sync #(.W(3), .RESET_VAL(3'h7)) u_sync_strb
  (
    .clock(clock),
    .rstn(rstn),
    .async_in({host_cs_n, host_rd_n, host_wr_n}),
    .sync_out({cs_n_s, rd_n_s, wr_n_s})
  );

  pin_sync #(.W(8), .RESET_VAL(8'h00)) u_sync_hdata
  (
    .clock(clock),
    .rstn(rstn),
    .async_in(host_data_in),
    .sync_out(hdata_s)
  );

  pin_sync #(.W(8), .RESET_VAL(8'h00)) u_sync_pdata
  (
    .clock(clock),
    .rstn(rstn),
    .async_in(port_data_pins_in),
    .sync_out(pdata_s)
  );

  pin_sync #(.W(4), .RESET_VAL(4'hF)) u_sync_cpin
  (
    .clock(clock),
    .rstn(rstn),
    .async_in(ctrl_pins_in),
    .sync_out(cpin_s)
  );

  pin_sync #(.W(5), .RESET_VAL(5'h1F)) u_sync_status
  (
    .clock(clock),
    .rstn(rstn),
    .async_in(status_pins),
    .sync_out(st_s)
  );

  // Strobe edge detection after synchronisation
  logic rd_n_d_r;
  logic wr_n_d_r;
  logic ack_n_d_r;
  logic epp_en_d_r;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rd_n_d_r <= 1'b1;
      wr_n_d_r <= 1'b1;
      ack_n_d_r <= 1'b1;
      epp_en_d_r <= 1'b0;
    end
    else
    begin
      rd_n_d_r <= rd_n_s;
      wr_n_d_r <= wr_n_s;
      ack_n_d_r <= st_s.ack_n;
      epp_en_d_r <= port_config_reg.epp_enable;
    end
  end

  // Reads act at the falling edge, writes commit at the rising edge
  // so the data bus has settled through the synchroniser.
  logic rd_start;
  logic wr_done;
  logic ack_rise;
  logic ack_fall;
  logic epp_en_rise;

  assign rd_start = rd_n_d_r && !rd_n_s && !cs_n_s;
  assign wr_done = !wr_n_d_r && wr_n_s && !cs_n_s;
  assign ack_rise = !ack_n_d_r && st_s.ack_n;
  assign ack_fall = ack_n_d_r && !st_s.ack_n;
  assign epp_en_rise = !epp_en_d_r && port_config_reg.epp_enable;

  // Mode decode
  logic ext_mode;
  logic epp_mode;
  logic ecp_mode;
  logic base_ok;
  logic irq_status_mode;

  assign ext_mode = port_config_reg.extended_mode_select;
  assign base_ok = (port_config_reg.port_base_sel == BASE_278) ||
                   (port_config_reg.port_base_sel == BASE_378);
  assign epp_mode = port_config_reg.epp_enable && base_ok;
  assign ecp_mode = port_config_reg.ecp_enable;
  assign irq_status_mode = ((epp_mode || ecp_mode) &&
                            port_config_reg.irq_status_en) ||
                           (ext_mode && !epp_mode && !ecp_mode);

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      epp_regs_present <= 1'b0;
      epp_rev19_active <= 1'b0;
    end
    else
    begin
      epp_regs_present <= epp_mode;
      epp_rev19_active <= epp_mode && port_config_reg.epp_rev19;
    end
  end

  logic wr_data;
  logic wr_ctrl;
  logic rd_status;

  // Status writes decode to nothing and leave all state alone
  assign wr_data = wr_done && (addr_s == OFF_DATA);
  assign wr_ctrl = wr_done && (addr_s == OFF_CONTROL);
  assign rd_status = rd_start && (addr_s == OFF_STATUS);

  // Data output latch
  logic [7:0] data_latch_r;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      data_latch_r <= DATA_RESET;
    end
    else if (wr_data)
    begin
      data_latch_r <= hdata_s;
    end
  end

  // Control latch: bits 0..5
  logic [5:0] ctrl_r;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      ctrl_r <= CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_r <= hdata_s[CT_DIR:CT_STROBE];
    end
  end

  logic dir_in;
  assign dir_in = ext_mode && ctrl_r[CT_DIR];

  // Data pin drive
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      port_data_pins_out <= DATA_RESET;
      port_data_pins_oe <= 1'b1;
    end
    else
    begin
      port_data_pins_out <= data_latch_r;
      port_data_pins_oe <= !dir_in;
    end
  end

  // Control pins: floated until software first writes the register,
  // except init which is driven low from reset.
  logic ctrl_written_r;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      ctrl_written_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      ctrl_written_r <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      printer_strobe_n <= 1'b1;
      auto_feed_n <= 1'b1;
      init_n <= 1'b0;
      select_in_n <= 1'b1;
      ctrl_pins_oe <= 4'h4;
    end
    else
    begin
      printer_strobe_n <= !ctrl_r[CT_STROBE];
      auto_feed_n <= !ctrl_r[CT_AFD];
      init_n <= ctrl_r[CT_INIT];
      select_in_n <= !ctrl_r[CT_SELECT_IN];
      ctrl_pins_oe <= {ctrl_written_r, 1'b1, ctrl_written_r,
                       ctrl_written_r};
    end
  end

  // EPP timeout detector
  logic [TMO_W-1:0] tmo_cnt_r;
  logic tmo_evt_r;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      tmo_cnt_r <= '0;
      tmo_evt_r <= 1'b0;
    end
    else
    begin
      tmo_evt_r <= 1'b0;
      if (!epp_mode || !epp_cycle_busy)
      begin
        tmo_cnt_r <= '0;
      end
      else if (tmo_cnt_r == TMO_W'(EPP_TIMEOUT_CYC - 1))
      begin
        // Parks past the terminal count so one busy spell pulses once
        tmo_evt_r <= 1'b1;
        tmo_cnt_r <= TMO_W'(EPP_TIMEOUT_CYC);
      end
      else if (tmo_cnt_r != TMO_W'(EPP_TIMEOUT_CYC))
      begin
        tmo_cnt_r <= tmo_cnt_r + TMO_W'(1);
      end
    end
  end

  // Timeout flag; a new timeout wins over a clear in the same cycle
  logic timeout_r;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      timeout_r <= 1'b0;
    end
    else if (tmo_evt_r)
    begin
      timeout_r <= 1'b1;
    end
    else if (rd_status || epp_en_rise)
    begin
      timeout_r <= 1'b0;
    end
  end

  // Interrupt status, active low; the acknowledge edge wins over a read
  logic irq_stat_n_r;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      irq_stat_n_r <= 1'b1;
    end
    else if (irq_status_mode && ctrl_r[CT_IRQEN] && ack_rise)
    begin
      irq_stat_n_r <= 1'b0;
    end
    else if (rd_status || !irq_status_mode)
    begin
      irq_stat_n_r <= 1'b1;
    end
  end

  // Register read mux
  logic [7:0] status_val;
  logic [7:0] ctrl_val;
  logic [7:0] data_val;
  logic [7:0] rd_val;

  always_comb
  begin
    status_val[ST_TIMEOUT] = epp_mode ? timeout_r : 1'b1;
    status_val[ST_RSVD] = 1'b1;
    status_val[ST_IRQ] = irq_status_mode ? irq_stat_n_r : 1'b1;
    status_val[ST_ERR] = st_s.err_n;
    status_val[ST_SEL] = st_s.printer_selected;
    status_val[ST_PE] = st_s.paper_end;
    status_val[ST_ACK] = st_s.ack_n;
    status_val[ST_BUSY] = !st_s.busy;
  end

  always_comb
  begin
    // Pin levels, so an externally forced line shows through
    ctrl_val[CT_STROBE] = !cpin_s[0];
    ctrl_val[CT_AFD] = !cpin_s[1];
    ctrl_val[CT_INIT] = cpin_s[2];
    ctrl_val[CT_SELECT_IN] = !cpin_s[3];
    ctrl_val[CT_IRQEN] = ctrl_r[CT_IRQEN];
    ctrl_val[CT_DIR] = epp_mode ? ctrl_r[CT_DIR] : 1'b1;
    ctrl_val[CT_RSVD_LO] = 1'b1;
    ctrl_val[CT_RSVD_HI] = 1'b1;
  end

  assign data_val = dir_in ? pdata_s : data_latch_r;

  always_comb
  begin
    unique case (addr_s)
      OFF_DATA: rd_val = data_val;
      OFF_STATUS: rd_val = status_val;
      OFF_CONTROL: rd_val = ctrl_val;
      OFF_NONE: rd_val = 8'h00;
    endcase
  end

  // Read data captured at the start of the read, before read side
  // effects alter the flags it reports.
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
    end
    else
    begin
      if (rd_start)
      begin
        host_data_out <= rd_val;
      end
      host_data_oe <= !rd_n_s && !cs_n_s && (addr_s != OFF_NONE);
    end
  end

  // Interrupt generation per mode
  logic irq_level_r;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      irq_level_r <= 1'b0;
    end
    else if (!ctrl_r[CT_IRQEN])
    begin
      irq_level_r <= 1'b0;
    end
    else if (epp_mode)
    begin
      irq_level_r <= ack_fall || tmo_evt_r;
    end
    else if (ext_mode)
    begin
      irq_level_r <= !irq_stat_n_r || ack_rise;
    end
    else
    begin
      irq_level_r <= !st_s.ack_n;
    end
  end

  // Line select 1 routes to line 5, 0 to line 7
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      irq5 <= 1'b0;
      irq7 <= 1'b0;
      irq5_oe <= 1'b0;
      irq7_oe <= 1'b0;
    end
    else
    begin
      irq5 <= irq_level_r;
      irq7 <= irq_level_r;
      irq5_oe <= ctrl_r[CT_IRQEN] && port_config_reg.irq_line_select;
      irq7_oe <= ctrl_r[CT_IRQEN] && !port_config_reg.irq_line_select;
    end
  end

endmodule

// >>> pport_pkg.sv
package pport_pkg;

  // Register offsets on the two host address bits
  localparam logic [1:0] OFF_DATA = 2'h0;
  localparam logic [1:0] OFF_STATUS = 2'h1;
  localparam logic [1:0] OFF_CONTROL = 2'h2;
  localparam logic [1:0] OFF_NONE = 2'h3;

  // Port base address choices
  localparam logic [1:0] BASE_278 = 2'h0;
  localparam logic [1:0] BASE_378 = 2'h1;
  localparam logic [1:0] BASE_3BC = 2'h2;

  // Status register bit positions
  localparam int ST_TIMEOUT = 0;
  localparam int ST_RSVD = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_ERR = 3;
  localparam int ST_SEL = 4;
  localparam int ST_PE = 5;
  localparam int ST_ACK = 6;
  localparam int ST_BUSY = 7;

  // Control register bit positions
  localparam int CT_STROBE = 0;
  localparam int CT_AFD = 1;
  localparam int CT_INIT = 2;
  localparam int CT_SELECT_IN = 3;
  localparam int CT_IRQEN = 4;
  localparam int CT_DIR = 5;
  localparam int CT_RSVD_LO = 6;
  localparam int CT_RSVD_HI = 7;

  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // EPP cycle timeout: least time 10 us at 125 MHz
  localparam int CLOCK_MHZ = 125;
  localparam int EPP_TIMEOUT_US = 10;
  localparam int EPP_TIMEOUT_CYC = EPP_TIMEOUT_US * CLOCK_MHZ;
  localparam int TMO_W = 11;

  // Printer status inputs, sampled together
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_end;
    logic printer_selected;
    logic err_n;
  } status_pins_t;

  // Port configuration bits held outside this block
  typedef struct packed {
    logic extended_mode_select;
    logic irq_line_select;
    logic epp_enable;
    logic epp_rev19;
    logic ecp_enable;
    logic irq_status_en;
    logic [1:0] port_base_sel;
  } port_config_t;

endpackage

// >>> pin_sync.sv
`timescale 1ns/1ns
module pin_sync
  #(parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0)
  (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Asynchronous in, synchronous out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
  );

  logic [W-1:0] meta_r;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// >>> pport_assertions.sv
`timescale 1ns/1ns
module pport_checker
  import pport_pkg::*;
  (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Watched ports
    input wire logic [1:0] host_addr,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_data_oe,
    input wire port_config_t port_config_reg,
    input wire logic port_data_pins_oe,
    input wire logic init_n,
    input wire logic [3:0] ctrl_pins_oe,
    input wire status_pins_t status_pins,
    input wire logic irq5,
    input wire logic irq5_oe,
    input wire logic irq7_oe,
    input wire logic epp_regs_present,
    input wire logic epp_rev19_active
  );
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_reset_pins: assert property (disable iff (1'h0) !rstn |=>
    !init_n && ctrl_pins_oe == 4'h4 && !irq5_oe && !irq7_oe)
    else $error("pin state after reset wrong");
  a_addr3_quiet: assert property (
    $rose(host_data_oe) |-> $past(host_addr, 2) != OFF_NONE)
    else $error("bus driven for empty address");
  a_read_drive: assert property (
    $fell(host_rd_n) && !host_cs_n && host_addr != OFF_NONE
    |-> ##[2:4] host_data_oe)
    else $error("read not driven");
  a_read_release: assert property ($rose(host_rd_n) |-> ##[2:4] !host_data_oe)
    else $error("bus not released");
  a_compat_drive: assert property (
    !port_config_reg.extended_mode_select
    && !$past(port_config_reg.extended_mode_select) |-> port_data_pins_oe)
    else $error("data pins not driven");
  a_irq5_route: assert property (
    irq5_oe |-> $past(port_config_reg.irq_line_select))
    else $error("wrong line enabled");
  a_compat_irq: assert property (
    irq5_oe && !port_config_reg.extended_mode_select
    && !port_config_reg.epp_enable
    && $past(status_pins.ack_n, 3) == $past(status_pins.ack_n, 4)
    |-> irq5 == !$past(status_pins.ack_n, 3))
    else $error("irq not following ack");
  a_epp_base: assert property (epp_regs_present |->
    $past(port_config_reg.epp_enable)
    && $past(port_config_reg.port_base_sel) != BASE_3BC)
    else $error("epp present wrongly");
  a_rev_select: assert property (epp_rev19_active |->
    $past(port_config_reg.epp_rev19) && $past(port_config_reg.epp_enable))
    else $error("revision wrong");
endmodule

bind printer_parallel_port_regs pport_checker chk_i (.clock, .rstn,
  .host_addr, .host_cs_n, .host_rd_n, .host_data_oe, .port_config_reg,
  .port_data_pins_oe, .init_n, .ctrl_pins_oe, .status_pins, .irq5,
  .irq5_oe, .irq7_oe, .epp_regs_present, .epp_rev19_active);

// >>> printer_model.sv
`timescale 1ns/1ns
module printer_model
  (
    // Drive from the port
    input wire logic [7:0] port_data_pins_out,
    input wire logic port_data_pins_oe,
    input wire logic [3:0] cp_out,
    input wire logic [3:0] ctrl_pins_oe,
    // Printer drive
    input wire logic [7:0] pd_drv,
    input wire logic pd_en,
    // Cable levels
    output logic [7:0] port_data_pins_in,
    output logic [3:0] ctrl_pins_in
  );
  // Released lines float up through the weak pull-ups
  always_comb
  begin
    port_data_pins_in = pd_en ? pd_drv : 8'hFF;
    if (port_data_pins_oe)
      port_data_pins_in = port_data_pins_out;
    for (int i = 0; i < 4; i++)
      ctrl_pins_in[i] = ctrl_pins_oe[i] ? cp_out[i] : 1'h1;
  end
endmodule

// >>> printer_parallel_port_regs_bench.sv
`timescale 1ns/1ns
module printer_parallel_port_regs_bench;
  import pport_pkg::*;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic host_cs_n = 1'h0;
  logic host_rd_n = 1'h1;
  logic host_wr_n = 1'h1;
  logic [1:0] host_addr = 2'h0;
  logic [7:0] host_data_in = 8'h00;
  port_config_t port_config_reg = '0;
  logic epp_cycle_busy = 1'h0;
  status_pins_t status_pins = '0;
  logic [7:0] pd_drv = 8'h00;
  logic pd_en = 1'h0;
  logic [7:0] host_data_out, port_data_pins_out, port_data_pins_in;
  logic host_data_oe, epp_regs_present, epp_rev19_active;
  logic port_data_pins_oe, printer_strobe_n, auto_feed_n, init_n;
  logic select_in_n, irq5, irq5_oe, irq7, irq7_oe;
  logic [3:0] ctrl_pins_in, ctrl_pins_oe, nib;
  logic [7:0] r, d;
  int n_errors = 0;
  int compares = 0;
  int n = 0;

  always #4 clock = ~clock;

  printer_model peer (.port_data_pins_out, .port_data_pins_oe,
    .cp_out({select_in_n, init_n, auto_feed_n, printer_strobe_n}),
    .ctrl_pins_oe, .pd_drv, .pd_en, .port_data_pins_in, .ctrl_pins_in);

  printer_parallel_port_regs DUT (.clock, .rstn, .host_addr, .host_cs_n,
    .host_rd_n, .host_wr_n, .host_data_in, .host_data_out, .host_data_oe,
    .port_config_reg, .epp_cycle_busy, .epp_regs_present, .epp_rev19_active,
    .port_data_pins_in, .port_data_pins_out, .port_data_pins_oe,
    .ctrl_pins_in, .printer_strobe_n, .auto_feed_n, .init_n, .select_in_n,
    .ctrl_pins_oe, .status_pins, .irq5, .irq5_oe, .irq7, .irq7_oe);

  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    compares++;
    if (s !== x)
    begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Write strobe held 4 cycles each way, read strobe 5, to clear the input synchronisers
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    host_addr <= a;
    host_data_in <= v;
    host_wr_n <= 1'h0;
    cyc(4);
    host_wr_n <= 1'h1;
    cyc(4);
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    host_addr <= a;
    host_rd_n <= 1'h0;
    cyc(5);
    chk(8'(host_data_oe), 8'(a != OFF_NONE));
    v = host_data_out;
    host_rd_n <= 1'h1;
    cyc(5);
  endtask

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'hB97BEE35));
    cyc(10);
    rstn <= 1'h1;
    cyc(1);
    chk(8'(init_n), 8'h00);
    rd(OFF_DATA, r);
    chk(r, DATA_RESET);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      nib = 4'($urandom);
      status_pins <= 5'($urandom);
      wr(OFF_CONTROL, {2'h0, i[0], 1'h0, nib});
      wr(OFF_DATA, d);
      wr(OFF_STATUS, ~d);
      chk(port_data_pins_out, d);
      chk(8'(port_data_pins_oe), 8'h01);
      rd(OFF_DATA, r);
      chk(r, d);
      chk(8'(ctrl_pins_in), 8'(nib ^ 4'hB));
      rd(OFF_CONTROL, r);
      chk(r, {4'hE, nib});
      rd(OFF_STATUS, r);
      chk(r, {~status_pins[4], status_pins[3:0], 3'h7});
      rd(OFF_NONE, r);
    end
    port_config_reg.extended_mode_select <= 1'h1;
    pd_drv <= 8'($urandom);
    pd_en <= 1'h1;
    wr(OFF_CONTROL, 8'h24);
    wr(OFF_DATA, d ^ 8'h5A);
    chk(8'(port_data_pins_oe), 8'h00);
    rd(OFF_DATA, r);
    chk(r, pd_drv);
    pd_en <= 1'h0;
    wr(OFF_CONTROL, 8'h04);
    chk(port_data_pins_out, d ^ 8'h5A);
    rd(OFF_DATA, r);
    chk(r, d ^ 8'h5A);
    status_pins.ack_n <= 1'h0;
    wr(OFF_CONTROL, 8'h14);
    status_pins.ack_n <= 1'h1;
    cyc(6);
    rd(OFF_STATUS, r);
    chk(8'(r[2]), 8'h00);
    rd(OFF_STATUS, r);
    chk(8'(r[2]), 8'h01);
    port_config_reg.extended_mode_select <= 1'h0;
    for (int ls = 0; ls < 2; ls++)
    begin
      wr(OFF_CONTROL, 8'h04);
      port_config_reg.irq_line_select <= ls[0];
      wr(OFF_CONTROL, 8'h14);
      status_pins.ack_n <= 1'h0;
      cyc(6);
      chk(8'({irq5_oe, irq7_oe, ls ? irq5 : irq7}),
        ls ? 8'h05 : 8'h03);
      status_pins.ack_n <= 1'h1;
      cyc(6);
      chk(8'(ls ? irq5 : irq7), 8'h00);
    end
    wr(OFF_CONTROL, 8'h04);
    cyc(2);
    chk(8'({irq5_oe, irq7_oe}), 8'h00);
    // Init bit is already 1 here, so EPP may be enabled
    port_config_reg.epp_rev19 <= 1'h1;
    port_config_reg.epp_enable <= 1'h1;
    for (int b = 2; b >= 0; b--)
    begin
      port_config_reg.port_base_sel <= 2'(b);
      cyc(3);
      chk(8'(epp_regs_present), 8'(b != 2));
      chk(8'(epp_rev19_active), 8'(b != 2));
    end
    epp_cycle_busy <= 1'h1;
    cyc(EPP_TIMEOUT_CYC + 20);
    epp_cycle_busy <= 1'h0;
    rd(OFF_STATUS, r);
    chk(8'(r[0]), 8'h01);
    rd(OFF_STATUS, r);
    chk(8'(r[0]), 8'h00);
    // EPP interrupt: one pulse for the ack fall, one for the timeout
    port_config_reg.irq_status_en <= 1'h1;
    wr(OFF_CONTROL, 8'h14);
    epp_cycle_busy <= 1'h1;
    status_pins.ack_n <= 1'h0;
    n = 0;
    repeat (EPP_TIMEOUT_CYC + 20)
    begin
      @(posedge clock);
      if (irq5 === 1'h1)
        n++;
    end
    chk(8'(n), 8'h02);
    epp_cycle_busy <= 1'h0;
    status_pins.ack_n <= 1'h1;
    cyc(6);
    // Re-enabling EPP must drop the pending timeout
    port_config_reg.epp_enable <= 1'h0;
    cyc(3);
    port_config_reg.epp_enable <= 1'h1;
    cyc(3);
    rd(OFF_STATUS, r);
    chk(8'(r[2:0]), 8'h06);
    status_pins.ack_n <= 1'h0;
    cyc(4);
    status_pins.ack_n <= 1'h1;
    cyc(6);
    rd(OFF_STATUS, r);
    chk(8'(r[2:0]), 8'h02);
    summarize();
  end
endmodule
